// *** rf_freq_power_control_tb_top.sv ***
`include "rfp_consts.svh"
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin err_count++; \
    $display("unexpected %s exp %0h got %0h", nm, ex, gt); end end
module rf_freq_power_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // Stimulus and DUT
    // ****************
    localparam int CAL = 20;
    localparam logic [6:0] P_ON = 7'h40, P_OFF = 7'h20, P_RXS = 7'h10, P_CS = 7'h08;
    localparam logic [6:0] P_TO = 7'h04, P_SYM = 7'h02, P_SH = 7'h01;
    localparam logic [7:0] RXC [6] = '{8'h90, 8'ha0, 8'h00, 8'hc3, 8'h55, 8'h80};
    localparam logic [3:0] PM [4] = '{4'h3, 4'hf, 4'h9, 4'h0};
    logic clock = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, radio_idle = 0;
    logic rx_active = 0, carrier_sensed = 0, tx_active = 0, tx_bit = 0, up, er, pready;
    logic pslverr, cal_start, cal_busy, cal_valid, rx_exit_to_idle, tuned;
    logic [6:0] pv = 7'h00;
    logic [7:0] paddr = 8'h00, ch, m, pa_level, tbl [8];
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [23:0] base;
    logic [4:0] f, if_word;
    logic [2:0] idx, lim;
    logic [`RFP_WORD_W-1:0] synth_word;
    int err_count = 0, checked = 0, exits = 0, cal_count, k, n, seed = 32'h4472;
    rfp_ctrl #(.CAL_CYCLES(CAL)) u_dut (.clock(clock), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .radio_idle(radio_idle), .synth_on(pv[6]),
        .auto_off(pv[5]), .rx_start(pv[4]), .rx_active(rx_active), .cs_valid(pv[3]),
        .carrier_sensed(carrier_sensed), .rx_timeout_nosync(pv[2]), .sym_tick(pv[1]),
        .shape_tick(pv[0]), .tx_active(tx_active), .tx_bit(tx_bit), .synth_word(synth_word),
        .if_word(if_word), .cal_start(cal_start), .cal_busy(cal_busy), .cal_valid(cal_valid),
        .rx_exit_to_idle(rx_exit_to_idle), .pa_level(pa_level));
    rfp_synth_model u_synth (.clock(clock), .reset_n(reset_n), .synth_word(synth_word),
        .cal_start(cal_start), .cal_busy(cal_busy), .cal_count(cal_count), .tuned(tuned));
    // Free-running clock and exit pulse counter
    initial forever #4 clock = ~clock;
    always @(posedge clock) if (rx_exit_to_idle === 1'b1) exits <= exits + 1;
    task automatic tally_and_finish();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Hang guard: counts as a mismatch
    initial begin
        repeat (100000) @(posedge clock);
        err_count++;
        tally_and_finish();
    end
    // APB transfer; waits for pready rather than assuming zero wait states
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_count++;
            tally_and_finish();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse(input logic [6:0] p);
        @(posedge clock);
        pv <= p;
        @(posedge clock);
        pv <= 7'h00;
    endtask
    // Ends on an edge so the next stimulus lands there; reads see settled flops
    task automatic idle(input int c);
        repeat (c) @(posedge clock);
    endtask
    function automatic logic [26:0] exp_word(input logic [23:0] b, input logic [7:0] c,
                                             input logic [7:0] s, input logic [1:0] e);
        return {1'b0, b, 2'h0} + ((27'(c) * (27'h100 + 27'(s))) << e);
    endfunction
    // ********
    // Sequence
    // ********
    initial begin
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        apb(1'b1, `RFP_A_STATUS, 8'hff);
        for (int a = 0; a < 'h54; a += 4) begin
            apb(1'b0, 8'(a), 8'h00);
            `CHK("map read", 33'(a == 'h50), {rd, er})
        end
        // Frequency word, random fields plus all-ones corner
        radio_idle <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            {base, ch, m, f} = 45'({$random(seed), $random(seed)});
            if (i == 7) {base, ch, m} = {24'hffffff, 8'hff, 8'hff};
            apb(1'b1, `RFP_A_BASE_HI, base[23:16]);
            apb(1'b1, `RFP_A_BASE_MID, base[15:8]);
            apb(1'b1, `RFP_A_BASE_LO, base[7:0]);
            apb(1'b1, `RFP_A_SLOT, ch);
            apb(1'b1, `RFP_A_MDM_HI, {6'h00, 2'(i)});
            apb(1'b1, `RFP_A_MDM_LO, m);
            apb(1'b1, `RFP_A_SYNTH, {3'h0, f});
            pulse(P_ON);
            idle(3);
            `CHK("word", exp_word(base, ch, m, 2'(i)), synth_word)
            `CHK("if word", f, if_word)
            apb(1'b1, `RFP_A_BASE_LO, ~base[7:0]);
            idle(3);
            `CHK("held word", exp_word(base, ch, m, 2'(i)), synth_word)
        end
        // Strobe outside idle is dropped; in idle it runs CAL cycles
        for (int s = 0; s < 2; s++) begin
            radio_idle <= 1'(s);
            k = cal_count;
            apb(1'b1, `RFP_A_CTRL, 8'h01);
            n = 0;
            while (cal_busy !== 1'b1 && n < 8) begin
                @(posedge clock);
                n++;
            end
            n = 0;
            while (cal_busy === 1'b1 && n < 99) begin
                @(posedge clock);
                n++;
            end
            idle(2);
            `CHK("cal run", {k + s, s * CAL, 1'(s)}, {cal_count, n, cal_valid})
            `CHK("tuned", 1'(s), tuned)
        end
        // Automatic modes: on turn-on, on auto return, every fourth return
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, `RFP_A_CALCFG, {2'h0, 2'(s), 4'h0});
            for (int j = 0; j < 8; j++) begin
                k = cal_count + int'((s == 1 && !j[0]) || (s == 2 && j[0])
                    || (s == 3 && j == 7));
                pulse(j[0] ? P_OFF : P_ON);
                idle(CAL + 8);
                `CHK("auto cal", k, cal_count)
            end
        end
        // Early exit: first sample, ASK symbol gate, disabled case, timeout
        rx_active <= 1'b1;
        apb(1'b1, `RFP_A_RXTO, 8'h10);
        foreach (RXC[i]) begin
            if (i == 5) apb(1'b1, `RFP_A_RXTO, 8'h00);
            apb(1'b1, `RFP_A_CTRL, {6'h00, RXC[i][6], 1'b0});
            if (RXC[i][7]) pulse(P_RXS);
            repeat (RXC[i][3:0]) pulse(P_SYM);
            carrier_sensed <= RXC[i][5];
            k = exits;
            pulse(P_CS);
            idle(3);
            `CHK("rx exit", int'(RXC[i][4]), exits - k)
        end
        k = exits;
        pulse(P_TO);
        idle(3);
        `CHK("timeout exit", k + 1, exits)
        rx_active <= 1'b0;
        // Power table envelope against a reference index
        for (int i = 0; i < 8; i++) begin
            tbl[i] = 8'($random(seed));
            if (tbl[i][7:3] == 5'h0d) tbl[i][7] = 1'b1;
            apb(1'b1, `RFP_A_TABLE + 8'(i * 4), tbl[i]);
        end
        idx = 3'h0;
        foreach (PM[p]) begin
            lim = PM[p][2:0];
            apb(1'b1, `RFP_A_FREND, {5'h00, lim});
            apb(1'b1, `RFP_A_CTRL, {6'h00, PM[p][3], 1'b0});
            if (idx > lim) idx = lim;
            for (int t = 0; t < 20; t++) begin
                up = PM[p][3] ? 1'($random(seed)) : (t < 10);
                tx_active <= up;
                tx_bit <= up;
                pulse(P_SH);
                idx = up ? ((idx < lim) ? idx + 3'h1 : idx) : ((idx > 0) ? idx - 3'h1 : idx);
                idle(3);
                `CHK("power level", tbl[idx], pa_level)
            end
        end
        tally_and_finish();
    end
endmodule // rf_freq_power_control_tb_top

// *** rfp_consts.svh ***
`ifndef RFP_CONSTS_SVH
`define RFP_CONSTS_SVH
// Register byte addresses
`define RFP_A_BASE_HI 8'h00
`define RFP_A_BASE_MID 8'h04
`define RFP_A_BASE_LO 8'h08
`define RFP_A_SLOT 8'h0c
`define RFP_A_MDM_HI 8'h10
`define RFP_A_MDM_LO 8'h14
`define RFP_A_SYNTH 8'h18
`define RFP_A_RXTO 8'h1c
`define RFP_A_CALCFG 8'h20
`define RFP_A_FREND 8'h24
`define RFP_A_CTRL 8'h28
`define RFP_A_STATUS 8'h2c
`define RFP_A_TABLE 8'h30
`define RFP_TABLE_SPAN 8'h20
// Reset value of every writable field
`define RFP_RST_BYTE 8'h00
// Field positions
`define RFP_EXP_HI 1
`define RFP_EXP_LO 0
`define RFP_IFW_HI 4
`define RFP_IFW_LO 0
`define RFP_EARLY_BIT 4
`define RFP_AUTOCAL_HI 5
`define RFP_AUTOCAL_LO 4
`define RFP_LIMIT_HI 2
`define RFP_LIMIT_LO 0
`define RFP_CTRL_CAL_BIT 0
`define RFP_CTRL_ASK_BIT 1
`define RFP_ST_BUSY_BIT 4
`define RFP_ST_VALID_BIT 5
// Frequency word arithmetic
`define RFP_SLOT_BASE 9'h100
`define RFP_WORD_W 27
`define RFP_FRAC_ZERO 2'h0
// Timing counts
`define RFP_ASK_SYMS 4'h8
`define RFP_CAL_CYCLES 19098
`endif

// *** rfp_ctrl.sv ***
`include "rfp_consts.svh"

// Function
// - Exit RX if first carrier sample low
// - ASK/OOK: no carrier valid after eight symbols
// - No-carrier or sync timeout exits go idle
// - Spacing given as mantissa and exponent
// - Base word: 24 bits in three bytes
// - 8-bit channel index scales spacing offset
// - Word = base + carrier_slot_index*(256+m)*2^(e-2)
// - IF equals reference/1024 times IF field
// - Auto calibrate on turn-on or auto turn-off
// - Calibrate strobe in idle starts calibration
// - Calibration result kept through sleep modes
// - Eight power entries, 3-bit index limit
// - Ramping walks entries zero up to limit
// - Limit zero: no ramp, entry zero only
// - OOK zero uses entry 0, one entry 1
// - ASK counter up on one, down on zero
// - Counter saturates at limit and zero
// - Option: calibrate every fourth auto idle return
module rfp_ctrl #(
    parameter int unsigned CAL_CYCLES = `RFP_CAL_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic radio_idle,
    input wire logic synth_on,
    input wire logic auto_off,
    input wire logic rx_start,
    input wire logic rx_active,
    input wire logic cs_valid,
    input wire logic carrier_sensed,
    input wire logic rx_timeout_nosync,
    input wire logic sym_tick,
    input wire logic shape_tick,
    input wire logic tx_active,
    input wire logic tx_bit,
    output logic [`RFP_WORD_W-1:0] synth_word,
    output logic [4:0] if_word,
    output logic cal_start,
    output logic cal_busy,
    output logic cal_valid,
    output logic rx_exit_to_idle,
    output logic [7:0] pa_level
);
    // ****************************************
    // Register bus
    // ****************************************
    rfp_pkg::rfp_byte_t base_word_high_q, base_word_mid_q, base_word_low_q;
    rfp_pkg::rfp_byte_t carrier_slot_register_q;
    rfp_pkg::rfp_byte_t modem_config_high_q, modem_config_low_q;
    rfp_pkg::rfp_byte_t synth_control_reg_q, rx_timeout_config_q;
    rfp_pkg::rfp_byte_t calibration_config_q, front_end_config_q;
    rfp_pkg::rfp_byte_t pa_table_q [8];
    logic ask_mode_q;
    logic calibrate_strobe_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic wr_en;
    logic rd_setup;
    logic [7:0] toff;
    logic in_table;
    logic [31:0] rdata_d;
    logic err_d;
    rfp_pkg::rfp_cal_state_e cal_state_q;
    logic [2:0] shape_index;

    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    assign toff = paddr - `RFP_A_TABLE;
    assign in_table = (toff < `RFP_TABLE_SPAN) && (toff[1:0] == 2'h0);

    // Zero wait states; read data is caught in the setup cycle
    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    // Configuration bytes, written in the access cycle only
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            base_word_high_q <= `RFP_RST_BYTE;
            base_word_mid_q <= `RFP_RST_BYTE;
            base_word_low_q <= `RFP_RST_BYTE;
            carrier_slot_register_q <= `RFP_RST_BYTE;
            modem_config_high_q <= `RFP_RST_BYTE;
            modem_config_low_q <= `RFP_RST_BYTE;
            synth_control_reg_q <= `RFP_RST_BYTE;
            rx_timeout_config_q <= `RFP_RST_BYTE;
            calibration_config_q <= `RFP_RST_BYTE;
            front_end_config_q <= `RFP_RST_BYTE;
            ask_mode_q <= 1'b0;
        end else if (wr_en) begin
            case (paddr)
                `RFP_A_BASE_HI: base_word_high_q <= pwdata[7:0];
                `RFP_A_BASE_MID: base_word_mid_q <= pwdata[7:0];
                `RFP_A_BASE_LO: base_word_low_q <= pwdata[7:0];
                `RFP_A_SLOT: carrier_slot_register_q <= pwdata[7:0];
                `RFP_A_MDM_HI: modem_config_high_q <= pwdata[7:0];
                `RFP_A_MDM_LO: modem_config_low_q <= pwdata[7:0];
                `RFP_A_SYNTH: synth_control_reg_q <= pwdata[7:0];
                `RFP_A_RXTO: rx_timeout_config_q <= pwdata[7:0];
                `RFP_A_CALCFG: calibration_config_q <= pwdata[7:0];
                `RFP_A_FREND: front_end_config_q <= pwdata[7:0];
                `RFP_A_CTRL: ask_mode_q <= pwdata[`RFP_CTRL_ASK_BIT];
                default: ;
            endcase
        end
    end

    // Power table, one byte per entry
    for (genvar i = 0; i < 8; i++) begin : g_table
        always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
                pa_table_q[i] <= `RFP_RST_BYTE;
            end else if (wr_en && in_table && toff[4:2] == 3'(i)) begin
                pa_table_q[i] <= pwdata[7:0];
            end
        end
    end

    // Calibrate strobe is a write-one pulse; it reads back as zero
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            calibrate_strobe_q <= 1'b0;
        end else begin
            calibrate_strobe_q <= wr_en && paddr == `RFP_A_CTRL
                                  && pwdata[`RFP_CTRL_CAL_BIT];
        end
    end

    // Read decode; an unmapped address answers zero with an error
    always_comb begin
        rdata_d = 32'h0;
        err_d = 1'b0;
        case (paddr)
            `RFP_A_BASE_HI: rdata_d[7:0] = base_word_high_q;
            `RFP_A_BASE_MID: rdata_d[7:0] = base_word_mid_q;
            `RFP_A_BASE_LO: rdata_d[7:0] = base_word_low_q;
            `RFP_A_SLOT: rdata_d[7:0] = carrier_slot_register_q;
            `RFP_A_MDM_HI: rdata_d[7:0] = modem_config_high_q;
            `RFP_A_MDM_LO: rdata_d[7:0] = modem_config_low_q;
            `RFP_A_SYNTH: rdata_d[7:0] = synth_control_reg_q;
            `RFP_A_RXTO: rdata_d[7:0] = rx_timeout_config_q;
            `RFP_A_CALCFG: rdata_d[7:0] = calibration_config_q;
            `RFP_A_FREND: rdata_d[7:0] = front_end_config_q;
            `RFP_A_CTRL: rdata_d[`RFP_CTRL_ASK_BIT] = ask_mode_q;
            `RFP_A_STATUS: begin
                rdata_d[2:0] = shape_index;
                rdata_d[`RFP_ST_BUSY_BIT] = cal_busy;
                rdata_d[`RFP_ST_VALID_BIT] = cal_valid;
            end
            default: begin
                if (in_table) begin
                    rdata_d[7:0] = pa_table_q[toff[4:2]];
                end else begin
                    err_d = 1'b1;
                end
            end
        endcase
    end

    // Answer registers, loaded in the setup cycle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
        end else if (rd_setup) begin
            prdata_q <= pwrite ? 32'h0 : rdata_d;
            pslverr_q <= err_d;
        end
    end

    // ****************************************
    // Frequency words
    // ****************************************
    logic [8:0] spacing;
    logic [16:0] slot_prod;
    logic [`RFP_WORD_W-1:0] word_calc;
    logic [`RFP_WORD_W-1:0] synth_word_q;
    logic [1:0] spacing_exponent;

    // Two fraction bits keep the exponent-minus-two scaling exact
    assign spacing_exponent = modem_config_high_q[`RFP_EXP_HI:`RFP_EXP_LO];
    assign spacing = `RFP_SLOT_BASE + {1'b0, modem_config_low_q};
    assign slot_prod = 17'(carrier_slot_register_q) * 17'(spacing);
    assign word_calc = `RFP_WORD_W'({base_word_high_q, base_word_mid_q,
                       base_word_low_q, `RFP_FRAC_ZERO})
                       + (`RFP_WORD_W'(slot_prod) << spacing_exponent);

    // Held between turn-ons so late register writes cannot pull the synth
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            synth_word_q <= `RFP_WORD_W'(0);
        end else if (synth_on) begin
            synth_word_q <= word_calc;
        end
    end

    assign synth_word = synth_word_q;
    assign if_word = synth_control_reg_q[`RFP_IFW_HI:`RFP_IFW_LO];

    // ****************************************
    // Calibration
    // ****************************************
    rfp_pkg::rfp_autocal_e auto_calibration_select;
    logic [1:0] auto_off_cnt_q;
    logic cal_req;
    logic [14:0] cal_cnt_q;
    logic cal_start_q;
    logic cal_valid_q;

    assign auto_calibration_select = rfp_pkg::rfp_autocal_e'(
        calibration_config_q[`RFP_AUTOCAL_HI:`RFP_AUTOCAL_LO]);

    // Requests from the strobe and the automatic options
    always_comb begin
        cal_req = calibrate_strobe_q && radio_idle;
        case (auto_calibration_select)
            rfp_pkg::RFP_CAL_ON_START: cal_req = cal_req || synth_on;
            rfp_pkg::RFP_CAL_ON_STOP: cal_req = cal_req || auto_off;
            rfp_pkg::RFP_CAL_EVERY_FOURTH: cal_req = cal_req
                || (auto_off && auto_off_cnt_q == 2'h3);
            default: ;
        endcase
    end

    // Counts automatic returns to idle in every-fourth mode only; wraps every fourth
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            auto_off_cnt_q <= 2'h0;
        end else if (auto_off
                     && auto_calibration_select == rfp_pkg::RFP_CAL_EVERY_FOURTH) begin
            auto_off_cnt_q <= auto_off_cnt_q + 2'h1;
        end
    end

    // Sequencer; a request during a run is dropped, not queued
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cal_state_q <= rfp_pkg::RFP_CAL_IDLE;
            cal_cnt_q <= 15'h0;
            cal_start_q <= 1'b0;
        end else begin
            cal_start_q <= 1'b0;
            case (cal_state_q)
                rfp_pkg::RFP_CAL_IDLE: begin
                    if (cal_req) begin
                        cal_state_q <= rfp_pkg::RFP_CAL_RUN;
                        cal_cnt_q <= 15'(CAL_CYCLES - 1);
                        cal_start_q <= 1'b1;
                    end
                end
                rfp_pkg::RFP_CAL_RUN: begin
                    if (cal_cnt_q == 15'h0) begin
                        cal_state_q <= rfp_pkg::RFP_CAL_IDLE;
                    end else begin
                        cal_cnt_q <= cal_cnt_q - 15'h1;
                    end
                end
                default: cal_state_q <= rfp_pkg::RFP_CAL_IDLE;
            endcase
        end
    end

    // Result validity survives sleep; only reset clears it
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cal_valid_q <= 1'b0;
        end else if (cal_state_q == rfp_pkg::RFP_CAL_RUN && cal_cnt_q == 15'h0) begin
            cal_valid_q <= 1'b1;
        end
    end

    assign cal_start = cal_start_q;
    assign cal_busy = cal_state_q == rfp_pkg::RFP_CAL_RUN;
    assign cal_valid = cal_valid_q;

    // ****************************************
    // Early receive exit
    // ****************************************
    logic [3:0] sym_cnt_q;
    logic first_done_q;
    logic no_carrier_ok;
    logic early_exit;
    logic go_idle_q;

    assign no_carrier_ok = !ask_mode_q || sym_cnt_q == `RFP_ASK_SYMS;
    assign early_exit = rx_timeout_config_q[`RFP_EARLY_BIT] && rx_active && cs_valid
                        && !first_done_q && !carrier_sensed && no_carrier_ok
                        && !rx_start;

    // Symbol periods since receive began, saturating
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sym_cnt_q <= 4'h0;
        end else if (rx_start) begin
            sym_cnt_q <= 4'h0;
        end else if (sym_tick && sym_cnt_q != `RFP_ASK_SYMS) begin
            sym_cnt_q <= sym_cnt_q + 4'h1;
        end
    end

    // Only the first sample that counts as valid decides
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            first_done_q <= 1'b0;
        end else if (rx_start) begin
            first_done_q <= 1'b0;
        end else if (rx_active && cs_valid && (carrier_sensed || no_carrier_ok)) begin
            first_done_q <= 1'b1;
        end
    end

    // Both causes force idle, whatever the after-receive setting
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            go_idle_q <= 1'b0;
        end else begin
            go_idle_q <= early_exit || rx_timeout_nosync;
        end
    end

    assign rx_exit_to_idle = go_idle_q;

    // ****************************************
    // Output power
    // ****************************************
    rfp_shape_if shape_bus ();
    logic [7:0] pa_level_q;

    assign shape_bus.tick = shape_tick;
    assign shape_bus.tx_active = tx_active;
    assign shape_bus.tx_bit = tx_bit;
    assign shape_bus.ask_mode = ask_mode_q;
    assign shape_bus.limit = front_end_config_q[`RFP_LIMIT_HI:`RFP_LIMIT_LO];
    assign shape_index = shape_bus.index;

    rfp_power_shaper u_shaper (
        .clock(clock),
        .reset_n(reset_n),
        .sh(shape_bus.shaper)
    );

    // OOK with limit one maps a zero to entry 0 and a one to entry 1
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pa_level_q <= `RFP_RST_BYTE;
        end else begin
            pa_level_q <= pa_table_q[shape_index];
        end
    end

    assign pa_level = pa_level_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    chk_word_latch: assert property (synth_on |=> synth_word == $past(word_calc))
        else $error("Word not latched at turn-on");
    chk_word_hold: assert property (!synth_on |=> $stable(synth_word))
        else $error("Word moved without turn-on");
    chk_manual_cal: assert property (
        calibrate_strobe_q && radio_idle && !cal_busy |=> cal_busy && $rose(cal_start))
        else $error("Strobe in idle did not calibrate");
    chk_auto_start: assert property (
        auto_calibration_select == rfp_pkg::RFP_CAL_ON_START && synth_on && !cal_busy
        |=> cal_start ##1 cal_busy)
        else $error("No calibration at turn-on");
    chk_fourth_skip: assert property (
        auto_calibration_select == rfp_pkg::RFP_CAL_EVERY_FOURTH && auto_off
        && auto_off_cnt_q != 2'h3 && !calibrate_strobe_q && !cal_busy |=> !cal_busy)
        else $error("Calibrated before fourth return");
    chk_early_exit: assert property (
        early_exit |=> rx_exit_to_idle ##1 (first_done_q || rx_start))
        else $error("Early exit not taken");
    chk_ask_wait: assert property (
        ask_mode_q && sym_cnt_q < `RFP_ASK_SYMS && !rx_timeout_nosync |=> !rx_exit_to_idle)
        else $error("ASK no-carrier taken too early");
    chk_timeout_idle: assert property (rx_timeout_nosync |=> rx_exit_to_idle)
        else $error("Timeout did not force idle");
    chk_level_pick: assert property (
        ##1 pa_level == $past(pa_table_q[shape_index]))
        else $error("Power level not from table");
    chk_zero_limit: assert property (
        shape_bus.limit == 3'h0 [*3] |-> shape_index == 3'h0 && pa_level == $past(pa_table_q[0]))
        else $error("Ramp with zero limit");

    cov_manual_cal: cover property (calibrate_strobe_q && radio_idle ##1 cal_busy);
    cov_early_exit: cover property (early_exit ##1 rx_exit_to_idle);
    cov_cal_done: cover property ($fell(cal_busy) && cal_valid);
endmodule // rfp_ctrl

// *** rfp_pkg.sv ***
package rfp_pkg;
    // Automatic calibration choices, in field encoding order
    typedef enum logic [1:0] {
        RFP_CAL_NEVER, RFP_CAL_ON_START, RFP_CAL_ON_STOP, RFP_CAL_EVERY_FOURTH
    } rfp_autocal_e;
    // Calibration sequencer states
    typedef enum logic {RFP_CAL_IDLE, RFP_CAL_RUN} rfp_cal_state_e;
    typedef logic [7:0] rfp_byte_t;
endpackage

// *** rfp_power_shaper.sv ***
`include "rfp_consts.svh"

module rfp_power_shaper (
    input wire logic clock,
    input wire logic reset_n,
    rfp_shape_if.shaper sh
);
    logic [2:0] index_q;
    logic step_up;

    // ASK follows the data bit, other formats follow the packet envelope
    assign step_up = sh.ask_mode ? sh.tx_bit : sh.tx_active;

    // Shaping counter, clamped at once if the limit is lowered
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            index_q <= 3'h0;
        end else if (index_q > sh.limit) begin
            index_q <= sh.limit;
        end else if (sh.tick) begin
            if (step_up && index_q != sh.limit) begin
                index_q <= index_q + 3'h1;
            end else if (!step_up && index_q != 3'h0) begin
                index_q <= index_q - 3'h1;
            end
        end
    end

    assign sh.index = index_q;

    // ****************************************
    // Checks
    // ****************************************
    chk_idx_saturate: assert property (@(posedge clock) disable iff (!reset_n)
        $stable(sh.limit) |-> index_q <= sh.limit)
        else $error("Shaping index above limit");
    chk_ask_count_up: assert property (@(posedge clock) disable iff (!reset_n)
        sh.tick && sh.ask_mode && sh.tx_bit && index_q < sh.limit
        |=> index_q == $past(index_q) + 3'h1)
        else $error("ASK counter did not step up");
    chk_ramp_down: assert property (@(posedge clock) disable iff (!reset_n)
        sh.tick && !sh.ask_mode && !sh.tx_active && index_q != 3'h0
        && index_q <= sh.limit |=> index_q == $past(index_q) - 3'h1)
        else $error("Ramp down did not step");
    cov_full_ramp: cover property (@(posedge clock) disable iff (!reset_n)
        index_q == 3'h7);
endmodule // rfp_power_shaper

// *** rfp_shape_if.sv ***
interface rfp_shape_if;
    logic tick;
    logic tx_active;
    logic tx_bit;
    logic ask_mode;
    logic [2:0] limit;
    logic [2:0] index;
    modport ctrl (output tick, output tx_active, output tx_bit, output ask_mode,
                  output limit, input index);
    modport shaper (input tick, input tx_active, input tx_bit, input ask_mode,
                    input limit, output index);
endinterface

// *** rfp_synth_model.sv ***
`include "rfp_consts.svh"
module rfp_synth_model (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [`RFP_WORD_W-1:0] synth_word,
    input wire logic cal_start,
    input wire logic cal_busy,
    output int cal_count,
    output logic tuned
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [`RFP_WORD_W-1:0] word_q;
    // Count runs; sleep keeps the result, so only a start moves it
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cal_count <= 0;
        end else if (cal_start) begin
            cal_count <= cal_count + 1;
        end
    end
    // A new word leaves the loop untuned until a run is seen
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tuned <= 1'b0;
            word_q <= '0;
        end else begin
            word_q <= synth_word;
            tuned <= (word_q == synth_word) && (tuned || cal_busy);
        end
    end
endmodule // rfp_synth_model
